// *** rtl/sam_pkg.sv ***
package sam_pkg;
    // register port widths, alarm, source and line counts, history depth
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int NUM_ALARM = 2;
    localparam int NUM_SRC = 7;
    localparam int NUM_LINE = 2;
    localparam int HIST_AW = 8;

    // register offsets
    localparam logic [AW-1:0] OFS_THRESH1 = 8'h26;
    localparam logic [AW-1:0] OFS_THRESH2 = 8'h28;
    localparam logic [AW-1:0] OFS_COUNT1 = 8'h2A;
    localparam logic [AW-1:0] OFS_COUNT2 = 8'h2C;
    localparam logic [AW-1:0] OFS_CONTROL = 8'h2E;
    localparam logic [AW-1:0] OFS_DIAG = 8'h3C;

    // reset values and writable bits
    localparam logic [DW-1:0] RST_REG = 16'h0000;
    localparam logic [DW-1:0] MASK_CONTROL = 16'hFFD7;
    localparam logic [DW-1:0] MASK_THRESH = 16'hBFFF;
    localparam logic [DW-1:0] MASK_COUNT = 16'h00FF;

    // control fields
    localparam int CTL_SRC1_LO = 8;
    localparam int CTL_SRC_W = 4;
    localparam int CTL_DYN1 = 6;
    localparam int CTL_FILT = 4;
    localparam int CTL_IND_EN = 2;
    localparam int CTL_IND_POL = 1;
    localparam int CTL_IND_LINE = 0;

    // threshold, count and status fields
    localparam int THR_POL = 15;
    localparam int THR_MSB = 13;
    localparam int CNT_MSB = 7;
    localparam int DIAG_ALM1 = 8;
    localparam logic [HIST_AW-1:0] CNT_ONE = 8'h01;
    localparam logic [HIST_AW-1:0] CNT_FULL = 8'hFF;

    // data source codes
    typedef enum logic [CTL_SRC_W-1:0] {
        SRC_OFF = 4'h0,
        SRC_GYRO_X = 4'h1,
        SRC_GYRO_Y = 4'h2,
        SRC_GYRO_Z = 4'h3,
        SRC_ACCEL_X = 4'h4,
        SRC_ACCEL_Y = 4'h5,
        SRC_ACCEL_Z = 4'h6,
        SRC_TEMP = 4'h7
    } sam_src_t;
endpackage : sam_pkg

// *** rtl/sam_history_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module sam_history_mem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // clock
    input wire logic i_clock,
    // write side
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    // read side
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on purpose: a fill counter outside guards unwritten words
    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
    end
endmodule : sam_history_mem
`default_nettype wire

// *** rtl/sam_monitor.sv ***
// Notes on behaviour
// R01: in dynamic mode an alarm judges the change of its source, not its value.
// R02: the dynamic change spans the programmed sample count and is compared to the threshold.
// R03: sample counts keep only bits 7:0, and both 0 and 1 mean one sample.
// R04: alarm 1 and alarm 2 conditions show in status bits 8 and 9.
// R05: control bits 15:12 pick alarm 2's source, 0 off, 1-3 gyro, 4-6 accel, 7 temperature.
// R06: control bits 11:8 pick alarm 1's source with the same codes.
// R07: control bits 7 and 6 make alarm 2 and alarm 1 dynamic when set, static when clear.
// R08: control bit 4 selects filtered sources when set, unfiltered when clear.
// R09: control bit 2 lets the alarm drive its indicator line, otherwise alarm logic leaves it.
// R10: control bit 1 makes the indicator active high when set, active low when clear.
// R11: control bit 0 routes the indicator to line two when set, line one when clear.
// R12: the dynamic interval in time is the sample count over the internal sample rate.
// R13: threshold bit 15 picks greater-than or less-than against a 14-bit threshold.
// R14: reading status clears its flags, and a lasting condition sets them on the next sample.
// R15: line ownership goes miscellaneous control first, then alarm, then general-purpose I/O.
// R16: both alarms are judged once per sample, updating flags and indicator from that sample.
`timescale 1ns/1ps
`default_nettype none
module sam_monitor (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    // register port
    input wire logic [sam_pkg::AW-1:0] I_REG_ADDR,
    input wire logic [sam_pkg::DW-1:0] I_REG_WDATA,
    input wire logic [1:0] I_REG_BE,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [sam_pkg::DW-1:0] O_REG_RDATA,
    // sensor samples
    input wire logic I_SAMPLE_STROBE,
    input wire logic [sam_pkg::NUM_SRC-1:0][sam_pkg::DW-1:0] I_RAW_SOURCE,
    input wire logic [sam_pkg::NUM_SRC-1:0][sam_pkg::DW-1:0] I_FILT_SOURCE,
    // digital lines
    input wire logic [sam_pkg::NUM_LINE-1:0] I_MISC_OUT,
    input wire logic [sam_pkg::NUM_LINE-1:0] I_MISC_OE,
    input wire logic [sam_pkg::NUM_LINE-1:0] I_GPIO_OUT,
    input wire logic [sam_pkg::NUM_LINE-1:0] I_GPIO_OE,
    output logic [sam_pkg::NUM_LINE-1:0] O_LINE_OUT,
    output logic [sam_pkg::NUM_LINE-1:0] O_LINE_OE,
    // status
    output logic [sam_pkg::NUM_ALARM-1:0] O_ALARM_STATUS
);
    import sam_pkg::*;

    logic [DW-1:0] thresh [NUM_ALARM];
    logic [DW-1:0] count [NUM_ALARM];
    logic [DW-1:0] control;
    logic [NUM_ALARM-1:0] diag_flag;
    logic [NUM_ALARM-1:0] alarm_live;
    logic [DW-1:0] rdata;
    logic [NUM_LINE-1:0] line_out;
    logic [NUM_LINE-1:0] line_oe;
    logic [DW-1:0] next_thresh [NUM_ALARM];
    logic [DW-1:0] next_count [NUM_ALARM];
    logic [DW-1:0] next_control;
    logic [NUM_ALARM-1:0] next_diag_flag;
    logic [NUM_ALARM-1:0] next_alarm_live;
    logic [DW-1:0] next_rdata;
    logic [NUM_LINE-1:0] next_line_out;
    logic [NUM_LINE-1:0] next_line_oe;
    logic [NUM_ALARM-1:0] hit;
    logic diag_read;
    logic ctrl_write;

    assign diag_read = I_REG_RD && (I_REG_ADDR == OFS_DIAG);
    assign ctrl_write = I_REG_WR && (I_REG_ADDR == OFS_CONTROL);

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] mask);
        logic [DW-1:0] val;
        val = old;
        if (I_REG_BE[1]) begin
            val[15:8] = I_REG_WDATA[15:8];
        end
        if (I_REG_BE[0]) begin
            val[7:0] = I_REG_WDATA[7:0];
        end
        merge = val & mask;
    endfunction : merge

    // register file, status flags and read data
    always_comb begin
        next_thresh = thresh;
        next_count = count;
        next_control = control;
        next_rdata = rdata;
        next_alarm_live = alarm_live;
        next_diag_flag = diag_flag;
        if (I_REG_WR) begin
            if (I_REG_ADDR == OFS_THRESH1) begin
                next_thresh[0] = merge(thresh[0], MASK_THRESH);
            end else if (I_REG_ADDR == OFS_THRESH2) begin
                next_thresh[1] = merge(thresh[1], MASK_THRESH);
            end else if (I_REG_ADDR == OFS_COUNT1) begin
                next_count[0] = merge(count[0], MASK_COUNT); // R03
            end else if (I_REG_ADDR == OFS_COUNT2) begin
                next_count[1] = merge(count[1], MASK_COUNT); // R03
            end else if (I_REG_ADDR == OFS_CONTROL) begin
                next_control = merge(control, MASK_CONTROL);
            end
        end
        if (I_REG_RD) begin
            if (I_REG_ADDR == OFS_THRESH1) begin
                next_rdata = thresh[0];
            end else if (I_REG_ADDR == OFS_THRESH2) begin
                next_rdata = thresh[1];
            end else if (I_REG_ADDR == OFS_COUNT1) begin
                next_rdata = count[0];
            end else if (I_REG_ADDR == OFS_COUNT2) begin
                next_rdata = count[1];
            end else if (I_REG_ADDR == OFS_CONTROL) begin
                next_rdata = control;
            end else if (I_REG_ADDR == OFS_DIAG) begin
                next_rdata = RST_REG;
                next_rdata[DIAG_ALM1 +: NUM_ALARM] = diag_flag; // R04
            end else begin
                next_rdata = RST_REG;
            end
        end
        if (diag_read) begin
            next_diag_flag = '0; // R14
        end
        if (I_SAMPLE_STROBE) begin
            next_alarm_live = hit; // R16
            next_diag_flag = next_diag_flag | hit; // R14
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            thresh <= '{default: RST_REG};
            count <= '{default: RST_REG};
            control <= RST_REG;
            rdata <= RST_REG;
            alarm_live <= '0;
            diag_flag <= '0;
        end else begin
            thresh <= next_thresh;
            count <= next_count;
            control <= next_control;
            rdata <= next_rdata;
            alarm_live <= next_alarm_live;
            diag_flag <= next_diag_flag;
        end
    end

    // per-alarm evaluation
    for (genvar a = 0; a < NUM_ALARM; a++) begin : g_alarm
        logic [CTL_SRC_W-1:0] src_code;
        logic [DW-1:0] src_data;
        logic src_on;
        logic dyn;
        logic [HIST_AW-1:0] n_eff;
        logic [HIST_AW-1:0] ptr;
        logic [HIST_AW-1:0] fill;
        logic [HIST_AW-1:0] next_ptr;
        logic [HIST_AW-1:0] next_fill;
        logic [DW-1:0] old_data;
        logic signed [THR_MSB+1:0] cur;
        logic signed [THR_MSB+1:0] past;
        logic signed [THR_MSB+1:0] thr_s;
        logic signed [THR_MSB+1:0] metric;
        logic ready;

        assign src_code = control[CTL_SRC1_LO + CTL_SRC_W*a +: CTL_SRC_W]; // R05 R06
        assign dyn = control[CTL_DYN1 + a]; // R07

        always_comb begin
            src_data = '0;
            src_on = 1'b0;
            for (int k = 0; k < NUM_SRC; k++) begin
                if (src_code == CTL_SRC_W'(k + 1)) begin
                    src_on = 1'b1; // R05 R06
                    src_data = control[CTL_FILT] ? I_FILT_SOURCE[k] : I_RAW_SOURCE[k]; // R08
                end
            end
        end

        // zero behaves as one sample
        assign n_eff = (count[a][CNT_MSB:0] == '0) ? CNT_ONE : count[a][CNT_MSB:0]; // R03
        assign cur = {src_data[THR_MSB], src_data[THR_MSB:0]};
        assign past = {old_data[THR_MSB], old_data[THR_MSB:0]};
        assign thr_s = {thresh[a][THR_MSB], thresh[a][THR_MSB:0]};
        // interval counted in samples, so its time is n_eff over the sample rate
        assign metric = dyn ? (cur - past) : cur; // R01 R02 R12
        assign ready = !dyn || (fill >= n_eff); // R02
        assign hit[a] = src_on && ready &&
                        (thresh[a][THR_POL] ? (metric > thr_s) : (metric < thr_s)); // R13

        sam_history_mem #(
            .AW(HIST_AW),
            .DW(DW)
        ) u_hist (
            .i_clock(I_CLOCK),
            .i_wr_en(I_SAMPLE_STROBE),
            .i_wr_addr(ptr),
            .i_wr_data(src_data),
            .i_rd_addr(ptr - n_eff),
            .o_rd_data(old_data)
        );

        // history restarts on every control write, since the source may have moved
        always_comb begin
            next_ptr = ptr;
            next_fill = fill;
            if (I_SAMPLE_STROBE) begin
                next_ptr = ptr + CNT_ONE;
                if (fill != CNT_FULL) begin
                    next_fill = fill + CNT_ONE;
                end
            end
            if (ctrl_write) begin
                next_fill = '0;
            end
        end

        always_ff @(posedge I_CLOCK) begin
            if (I_SRST) begin
                ptr <= '0;
                fill <= '0;
            end else begin
                ptr <= next_ptr;
                fill <= next_fill;
            end
        end
    end

    // digital line ownership
    always_comb begin
        logic ind_act;
        ind_act = |alarm_live;
        next_line_out = I_GPIO_OUT;
        next_line_oe = I_GPIO_OE;
        for (int j = 0; j < NUM_LINE; j++) begin
            if (I_MISC_OE[j]) begin
                next_line_out[j] = I_MISC_OUT[j]; // R15
                next_line_oe[j] = 1'b1;
            end else if (control[CTL_IND_EN] && (control[CTL_IND_LINE] == j[0])) begin // R09 R11
                next_line_out[j] = control[CTL_IND_POL] ? ind_act : !ind_act; // R10
                next_line_oe[j] = 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            line_out <= '0;
            line_oe <= '0;
        end else begin
            line_out <= next_line_out;
            line_oe <= next_line_oe;
        end
    end

    assign O_REG_RDATA = rdata;
    assign O_LINE_OUT = line_out;
    assign O_LINE_OE = line_oe;
    assign O_ALARM_STATUS = diag_flag;

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);

    sequence status_read_s;
        diag_read && !I_SAMPLE_STROBE;
    endsequence

    sequence alarm1_sample_s;
        I_SAMPLE_STROBE && hit[0];
    endsequence

    // a status read in the flagged cycle may clear it one cycle on
    flag_set_a: assert property (alarm1_sample_s |=> diag_flag[0] ##1 // R04
                                 (O_ALARM_STATUS[0] || $past(diag_read)))
        else $error("alarm 1 flag not set by sample");
    flag_clear_a: assert property (status_read_s |=> diag_flag == '0) // R14
        else $error("status read did not clear flags");
    flag_read_a: assert property (diag_read |=> // R04
                                  O_REG_RDATA[DIAG_ALM1 +: NUM_ALARM] == $past(diag_flag))
        else $error("status read data wrong");
    count_byte_a: assert property (I_REG_RD && I_REG_ADDR == OFS_COUNT1 |=> // R03
                                   O_REG_RDATA[15:8] == 8'h00)
        else $error("count upper byte not zero");
    source_off_a: assert property (control[CTL_SRC1_LO +: CTL_SRC_W] == SRC_OFF |-> // R06
                                   !hit[0])
        else $error("disabled alarm 1 raised");
    dyn_wait_a: assert property (control[CTL_DYN1 + 1] && // R02
                                 g_alarm[1].fill < g_alarm[1].n_eff |-> !hit[1])
        else $error("dynamic alarm 2 before history ready");
    ind_off_a: assert property (!control[CTL_IND_EN] && I_MISC_OE == '0 |=> // R09
                                O_LINE_OE == $past(I_GPIO_OE) && O_LINE_OUT == $past(I_GPIO_OUT))
        else $error("indicator drives while disabled");
    ind_level_a: assert property (control[CTL_IND_EN] && !control[CTL_IND_LINE] && // R10
                                  !I_MISC_OE[0] && (|alarm_live) |=>
                                  O_LINE_OE[0] && O_LINE_OUT[0] == $past(control[CTL_IND_POL]))
        else $error("indicator level or line wrong");
    misc_first_a: assert property (I_MISC_OE[1] |=> // R15
                                   O_LINE_OE[1] && O_LINE_OUT[1] == $past(I_MISC_OUT[1]))
        else $error("miscellaneous control lost line two");
    sample_live_a: assert property (I_SAMPLE_STROBE |=> alarm_live == $past(hit) ##1 // R16
                                    ($stable(alarm_live) || I_SAMPLE_STROBE))
        else $error("alarm state not from sample");
endmodule : sam_monitor
`default_nettype wire

// *** tb/sam_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sam_sensor_model (
    // clock
    input wire logic i_clock,
    // sample side
    output logic o_strobe,
    output logic [sam_pkg::NUM_SRC-1:0][sam_pkg::DW-1:0] o_raw,
    output logic [sam_pkg::NUM_SRC-1:0][sam_pkg::DW-1:0] o_filt
);
    import sam_pkg::*;

    initial begin
        o_strobe = 1'b0;
        o_raw = '0;
        o_filt = '0;
    end

    // one sample period: the chosen source carries the value, the rest are zero
    task automatic sample(input int idx, input logic [DW-1:0] raw, input logic [DW-1:0] filt);
        @(posedge i_clock);
        #1;
        o_raw = '0;
        o_filt = '0;
        o_raw[idx] = raw;
        o_filt[idx] = filt;
        o_strobe = 1'b1;
        @(posedge i_clock);
        #1;
        o_strobe = 1'b0;
        // scrambled outside the strobe so nothing can lean on stale data
        o_raw = ~o_raw;
        o_filt = ~o_filt;
        repeat (2) @(posedge i_clock);
        #1;
    endtask : sample
endmodule : sam_sensor_model
`default_nettype wire

// *** tb/sam_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sam_monitor_tb;
    import sam_pkg::*;
    logic clk;
    logic srst;
    logic wr;
    logic rd;
    logic [1:0] be;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic strobe;
    logic [NUM_SRC-1:0][DW-1:0] raw;
    logic [NUM_SRC-1:0][DW-1:0] filt;
    logic [NUM_LINE-1:0] misc_out, misc_oe, gpio_out, gpio_oe, line_out, line_oe, exp_out;
    logic [NUM_ALARM-1:0] status;
    int errors = 0;
    int cmp_count = 0;

    sam_monitor sam_monitor_inst (
        .I_CLOCK(clk), .I_SRST(srst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_BE(be), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .I_SAMPLE_STROBE(strobe), .I_RAW_SOURCE(raw), .I_FILT_SOURCE(filt),
        .I_MISC_OUT(misc_out), .I_MISC_OE(misc_oe), .I_GPIO_OUT(gpio_out),
        .I_GPIO_OE(gpio_oe), .O_LINE_OUT(line_out), .O_LINE_OE(line_oe),
        .O_ALARM_STATUS(status)
    );

    sam_sensor_model sam_sensor_model_inst (
        .i_clock(clk), .o_strobe(strobe), .o_raw(raw), .o_filt(filt)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic print_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                          input logic [1:0] b = 2'b11);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        be = b;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask : reg_wr

    task automatic reg_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        chk(rdata, e);
    endtask : reg_chk

    // status read after every sample keeps flags from leaking into the next case
    task automatic samp_chk(input int idx, input logic [DW-1:0] r, input logic [DW-1:0] f,
                            input logic [1:0] e);
        sam_sensor_model_inst.sample(idx, r, f);
        chk({14'h0000, status}, {14'h0000, e});
        reg_chk(OFS_DIAG, {6'h00, e, 8'h00});
    endtask : samp_chk

    initial begin
        #40000;
        errors++;
        print_verdict();
    end

    initial begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        be = 2'b11;
        addr = '0;
        wdata = '0;
        misc_out = 2'b00;
        misc_oe = 2'b00;
        gpio_out = 2'b01;
        gpio_oe = 2'b01;
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        reg_chk(OFS_CONTROL, 16'h0000);
        reg_chk(OFS_COUNT2, 16'h0000);
        reg_wr(OFS_COUNT1, 16'hFFFF);
        reg_chk(OFS_COUNT1, 16'h00FF);
        reg_wr(OFS_THRESH1, 16'hFFFF);
        reg_chk(OFS_THRESH1, 16'hBFFF);
        reg_wr(OFS_CONTROL, 16'hFFFF);
        reg_chk(OFS_CONTROL, 16'hFFD7);
        reg_wr(OFS_CONTROL, 16'h1234, 2'b10);
        reg_chk(OFS_CONTROL, 16'h12D7);
        reg_wr(OFS_CONTROL, 16'h0000);
        reg_wr(OFS_THRESH1, 16'h8064);
        reg_wr(OFS_THRESH2, 16'h8064);
        samp_chk(0, 16'h00C8, 16'h00C8, 2'b00);
        reg_wr(OFS_CONTROL, 16'h0100);
        samp_chk(0, 16'h00C8, 16'h0000, 2'b01);
        chk({12'h000, line_oe, line_out}, {12'h000, gpio_oe, gpio_out});
        reg_chk(OFS_DIAG, 16'h0000);
        for (int c = 1; c <= 7; c++) begin
            reg_wr(OFS_CONTROL, {c[3:0], 12'h000});
            samp_chk(c % 7, 16'h00C8, 16'h0000, 2'b00);
            samp_chk(c - 1, 16'h00C8, 16'h0000, 2'b10);
            reg_wr(OFS_CONTROL, {4'h0, c[3:0], 8'h00});
            samp_chk(c - 1, 16'h00C8, 16'h0000, 2'b01);
        end
        reg_wr(OFS_THRESH1, 16'h02BC);
        reg_wr(OFS_CONTROL, 16'h0600);
        samp_chk(5, 16'h0258, 16'h0000, 2'b01);
        samp_chk(5, 16'h0320, 16'h0000, 2'b00);
        samp_chk(5, 16'h3FFF, 16'h0000, 2'b01);
        reg_wr(OFS_THRESH1, 16'h8064);
        reg_wr(OFS_CONTROL, 16'h0110);
        samp_chk(0, 16'h0000, 16'h00C8, 2'b01);
        samp_chk(0, 16'h00C8, 16'h0000, 2'b00);
        for (int k = 0; k < 4; k++) begin
            reg_wr(OFS_CONTROL, {12'h010, 2'b01, k[1:0]});
            for (int h = 0; h < 2; h++) begin
                samp_chk(0, h[0] ? 16'h00C8 : 16'h0000, 16'h0000, h[1:0]);
                exp_out = gpio_out;
                exp_out[k[0]] = h[0] ? k[1] : ~k[1];
                chk({12'h000, line_oe, line_out},
                    {12'h000, gpio_oe | (2'b01 << k[0]), exp_out});
            end
        end
        misc_oe = 2'b11;
        misc_out = 2'b10;
        samp_chk(0, 16'h00C8, 16'h0000, 2'b01);
        chk({12'h000, line_oe, line_out}, 16'h000E);
        misc_oe = 2'b00;
        // dynamic: a steady large value must stay quiet, only the change counts
        reg_wr(OFS_COUNT2, 16'h0002);
        reg_wr(OFS_CONTROL, 16'h3080);
        repeat (3) samp_chk(2, 16'h01F4, 16'h0000, 2'b00);
        samp_chk(2, 16'h02BC, 16'h0000, 2'b10);
        samp_chk(2, 16'h02BC, 16'h0000, 2'b10);
        samp_chk(2, 16'h02BC, 16'h0000, 2'b00);
        reg_wr(OFS_COUNT2, 16'h0000);
        reg_wr(OFS_CONTROL, 16'h3080);
        repeat (2) samp_chk(2, 16'h01F4, 16'h0000, 2'b00);
        samp_chk(2, 16'h02BC, 16'h0000, 2'b10);
        samp_chk(2, 16'h02BC, 16'h0000, 2'b00);
        reg_wr(OFS_COUNT1, 16'h0001);
        reg_wr(OFS_CONTROL, 16'h0340);
        repeat (2) samp_chk(2, 16'h01F4, 16'h0000, 2'b00);
        samp_chk(2, 16'h02BC, 16'h0000, 2'b01);
        print_verdict();
    end
endmodule : sam_monitor_tb
`default_nettype wire
